/* pkg/ckr_pkg.sv */
// Purpose: Shared constants and types for the clock generator register port.
// Assumes: Two-wire bus with 7-bit addressing, sixteen 8-bit registers.
// Notes:   Used by both the register slave and the bus master ends.
package ckr_pkg;
    localparam logic [6:0] CKR_SLAVE_ADDR  = 7'h5C;
    localparam int         CKR_NUM_REGS    = 16;
    localparam int         CKR_PTR_W       = 4;
    localparam logic [7:0] CKR_REG_RESET   = 8'h00;
    localparam logic [2:0] CKR_BIT_LAST    = 3'h7;
    localparam int         CKR_SCL_HALF    = 4;
    localparam logic       CKR_DIR_WRITE   = 1'b0;
    localparam logic       CKR_DIR_READ    = 1'b1;

    // Slave bus states.
    typedef enum logic [2:0] {
        CKR_S_IDLE   = 3'b000,
        CKR_S_ADDR   = 3'b001,
        CKR_S_AACK   = 3'b011,
        CKR_S_PTR    = 3'b010,
        CKR_S_WDATA  = 3'b110,
        CKR_S_WACK   = 3'b111,
        CKR_S_RDATA  = 3'b101,
        CKR_S_RACK   = 3'b100
    } ckr_sstate_t;

    // Master sequencer states.
    typedef enum logic [2:0] {
        CKR_M_IDLE  = 3'b000,
        CKR_M_START = 3'b001,
        CKR_M_BIT   = 3'b011,
        CKR_M_ACK   = 3'b010,
        CKR_M_STOP  = 3'b110,
        CKR_M_DONE  = 3'b111
    } ckr_mstate_t;
endpackage : ckr_pkg

/* pkg/ckr_if.sv */
// Purpose: Two-wire link between the bus master and the register slave.
// Assumes: Open-drain lines with pull-ups resolved here from the enables.
// Notes:   A low output with enable high pulls the wire low.
`timescale 1ns/1ps
interface ckr_if;
    logic scl_o;
    logic scl_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;

    assign scl = !(scl_oe && !scl_o);
    assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

    modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe,
                    input scl, input sda);
    modport slave  (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface : ckr_if

/* logic/ckr_slave.sv */
// Overview of operation
// - Respond as slave only, ignore general call.
// - Master drives clock and all bus conditions.
// - Transfers start only from idle bus.
// - SDA falling while SCL high means START.
// - SDA rising while SCL high means STOP.
// - SDA changes with SCL high are conditions.
// - One clock per bit plus acknowledge clock.
// - Receiver holds SDA low during acknowledge.
// - Master nacks last read byte; slave releases.
// - Master sends address then direction bit.
// - Answer only address 1011100.
// - Write: pointer byte, then data byte.
// - Partial byte discarded on STOP or START.
// - Read: set pointer, repeated START, read.
// - Pointer increments after write, wraps at 16.
// - Excess bytes overwrite from first onward.
// - Each written byte acknowledged before next.
// - Register commits at its acknowledge; here it commits on the SCL rise of its eighth data bit.
// - Sequential read increments pointer and wraps.
// - Serial port works only while mode low.
// - Entering program mode clears all registers.
// - Registers reset to zero.
//
// Purpose: Register slave of the clock generator on the two-wire bus.
// Assumes: Link logic runs on clk_link, an oversampling clock faster than SCL.
// Notes:   Register contents go to the system domain as a registered copy
//          taken only while the serial interface is idle.
`timescale 1ns/1ps
module ckr_slave (
    // Clocks and reset
    input  wire logic        clk_sys,
    input  wire logic        clk_link,
    input  wire logic        rstn,
    // Bus link
    ckr_if.slave             bus,
    // User side
    input  wire logic        mode_run,
    output logic [127:0]     regs_out,
    output logic             prog_busy
);
    logic [7:0]                regs_reg [ckr_pkg::CKR_NUM_REGS];
    logic [1:0]                scl_sync_reg;
    logic [1:0]                sda_sync_reg;
    logic [1:0]                mode_sync_reg;
    logic                      scl_d_reg;
    logic                      sda_d_reg;
    logic                      mode_d_reg;
    logic                      scl_s;
    logic                      sda_s;
    logic                      mode_s;
    logic                      start_det;
    logic                      stop_det;
    logic                      scl_rise;
    logic                      scl_fall;
    ckr_pkg::ckr_sstate_t      state_reg;
    logic [2:0]                bit_reg;
    logic [7:0]                shift_reg;
    logic [ckr_pkg::CKR_PTR_W-1:0] ptr_reg;
    logic                      sda_drive_reg;
    logic                      busy_link_reg;
    logic [1:0]                busy_sys_reg;
    logic [7:0]                rx_byte;

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            scl_sync_reg  <= 2'h3;
            sda_sync_reg  <= 2'h3;
            mode_sync_reg <= 2'h3;
        end else begin
            scl_sync_reg  <= {scl_sync_reg[0], bus.scl};
            sda_sync_reg  <= {sda_sync_reg[0], bus.sda};
            mode_sync_reg <= {mode_sync_reg[0], mode_run};
        end
    end

    assign scl_s  = scl_sync_reg[1];
    assign sda_s  = sda_sync_reg[1];
    assign mode_s = mode_sync_reg[1];

    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            scl_d_reg  <= 1'b1;
            sda_d_reg  <= 1'b1;
            mode_d_reg <= 1'b1;
        end else begin
            scl_d_reg  <= scl_s;
            sda_d_reg  <= sda_s;
            mode_d_reg <= mode_s;
        end
    end

    // ------------------------------------------------------------
    // Bus condition detection
    // ------------------------------------------------------------
    // Pins are serial lines only in program mode.
    assign start_det = !mode_s && scl_s && scl_d_reg && sda_d_reg && !sda_s;
    assign stop_det  = !mode_s && scl_s && scl_d_reg && !sda_d_reg && sda_s;
    assign scl_rise  = !mode_s && scl_s && !scl_d_reg;
    assign scl_fall  = !mode_s && !scl_s && scl_d_reg;
    assign rx_byte   = {shift_reg[6:0], sda_s};

    // ------------------------------------------------------------
    // Protocol state machine
    // ------------------------------------------------------------
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ckr_pkg::CKR_S_IDLE;
            bit_reg   <= 3'h0;
            shift_reg <= 8'h00;
            ptr_reg   <= 4'h0;
        end else if (mode_s) begin
            state_reg <= ckr_pkg::CKR_S_IDLE;
            bit_reg   <= 3'h0;
        end else if (start_det) begin
            // A partly shifted byte is simply dropped here.
            state_reg <= ckr_pkg::CKR_S_ADDR;
            bit_reg   <= 3'h0;
        end else if (stop_det) begin
            state_reg <= ckr_pkg::CKR_S_IDLE;
        end else begin
            case (state_reg)
                ckr_pkg::CKR_S_ADDR, ckr_pkg::CKR_S_PTR, ckr_pkg::CKR_S_WDATA: begin
                    if (scl_rise) begin
                        shift_reg <= rx_byte;
                        bit_reg   <= bit_reg + 3'h1;
                    end
                    if (scl_rise && bit_reg == ckr_pkg::CKR_BIT_LAST) begin
                        if (state_reg == ckr_pkg::CKR_S_ADDR) begin
                            // Only our address is answered; general call falls out.
                            state_reg <= (rx_byte[7:1] == ckr_pkg::CKR_SLAVE_ADDR)
                                         ? ckr_pkg::CKR_S_AACK : ckr_pkg::CKR_S_IDLE;
                        end else if (state_reg == ckr_pkg::CKR_S_PTR) begin
                            ptr_reg   <= rx_byte[3:0];
                            state_reg <= ckr_pkg::CKR_S_WACK;
                        end else begin
                            state_reg <= ckr_pkg::CKR_S_WACK;
                            ptr_reg   <= ptr_reg + 4'h1;
                        end
                    end
                end
                ckr_pkg::CKR_S_AACK: begin
                    if (scl_fall && sda_drive_reg) begin
                        state_reg <= (shift_reg[0] == ckr_pkg::CKR_DIR_READ)
                                     ? ckr_pkg::CKR_S_RDATA : ckr_pkg::CKR_S_PTR;
                        shift_reg <= regs_reg[ptr_reg];
                    end
                end
                ckr_pkg::CKR_S_WACK: begin
                    if (scl_fall && sda_drive_reg) begin
                        state_reg <= ckr_pkg::CKR_S_WDATA;
                    end
                end
                ckr_pkg::CKR_S_RDATA: begin
                    if (scl_fall) begin
                        shift_reg <= {shift_reg[6:0], 1'b1};
                        bit_reg   <= bit_reg + 3'h1;
                        if (bit_reg == ckr_pkg::CKR_BIT_LAST) begin
                            state_reg <= ckr_pkg::CKR_S_RACK;
                            ptr_reg   <= ptr_reg + 4'h1;
                        end
                    end
                end
                ckr_pkg::CKR_S_RACK: begin
                    if (scl_rise) begin
                        // A nack ends the read and leaves SDA released.
                        state_reg <= sda_s ? ckr_pkg::CKR_S_IDLE : ckr_pkg::CKR_S_RACK;
                    end else if (scl_fall) begin
                        state_reg <= ckr_pkg::CKR_S_RDATA;
                        shift_reg <= regs_reg[ptr_reg];
                    end
                end
                default: state_reg <= ckr_pkg::CKR_S_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // Register file and commit on the SCL rise of the last data bit
    // ------------------------------------------------------------
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            for (int i = 0; i < ckr_pkg::CKR_NUM_REGS; i++) begin
                regs_reg[i] <= ckr_pkg::CKR_REG_RESET;
            end
        end else if (!mode_s && mode_d_reg) begin
            for (int i = 0; i < ckr_pkg::CKR_NUM_REGS; i++) begin
                regs_reg[i] <= ckr_pkg::CKR_REG_RESET;
            end
        end else if (!mode_s && !start_det && !stop_det && state_reg == ckr_pkg::CKR_S_WDATA
                     && scl_rise && bit_reg == ckr_pkg::CKR_BIT_LAST) begin
            regs_reg[ptr_reg] <= rx_byte;
        end
    end

    // Commit strobe keeps the busy flag up for one cycle after a written byte.
    logic wr_commit_reg;
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            wr_commit_reg <= 1'b0;
        end else begin
            wr_commit_reg <= !mode_s && !start_det && !stop_det
                             && state_reg == ckr_pkg::CKR_S_WDATA && scl_rise
                             && bit_reg == ckr_pkg::CKR_BIT_LAST;
        end
    end

    // ------------------------------------------------------------
    // SDA drive
    // ------------------------------------------------------------
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            sda_drive_reg <= 1'b0;
        end else if (mode_s || start_det || stop_det) begin
            sda_drive_reg <= 1'b0;
        end else if (scl_fall) begin
            case (state_reg)
                ckr_pkg::CKR_S_AACK, ckr_pkg::CKR_S_WACK: sda_drive_reg <= !sda_drive_reg;
                ckr_pkg::CKR_S_RDATA: sda_drive_reg <= (bit_reg != ckr_pkg::CKR_BIT_LAST)
                                                      && !shift_reg[6];
                ckr_pkg::CKR_S_RACK:  sda_drive_reg <= !regs_reg[ptr_reg][7];
                default:              sda_drive_reg <= 1'b0;
            endcase
        end else if (state_reg == ckr_pkg::CKR_S_RDATA && bit_reg == 3'h0 && scl_d_reg == 1'b0
                     && !scl_s && shift_reg == regs_reg[ptr_reg]) begin
            sda_drive_reg <= !shift_reg[7];
        end
    end

    assign bus.sda_s_o  = 1'b0;
    assign bus.sda_s_oe = sda_drive_reg;

    // ------------------------------------------------------------
    // Crossing to the system domain
    // ------------------------------------------------------------
    always_ff @(posedge clk_link or negedge rstn) begin
        if (!rstn) begin
            busy_link_reg <= 1'b0;
        end else begin
            busy_link_reg <= (state_reg != ckr_pkg::CKR_S_IDLE) || wr_commit_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            busy_sys_reg <= 2'h0;
        end else begin
            busy_sys_reg <= {busy_sys_reg[0], busy_link_reg};
        end
    end

    assign prog_busy = busy_sys_reg[1];

    // Snapshot is taken only while the link is quiet, so the words are stable.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            regs_out <= 128'h0;
        end else if (!busy_sys_reg[1]) begin
            for (int i = 0; i < ckr_pkg::CKR_NUM_REGS; i++) begin
                regs_out[i*8 +: 8] <= regs_reg[i];
            end
        end
    end
endmodule : ckr_slave

/* logic/ckr_master.sv */
// Purpose: Two-wire bus master that writes or reads one register byte.
// Assumes: SCL is derived from clk_sys by a divider and driven out.
// Notes:   Write: START, addr+W, pointer, data, STOP.
//          Read: START, addr+W, pointer, repeated START, addr+R, data, NACK, STOP.
`timescale 1ns/1ps
module ckr_master (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rstn,
    // Bus link
    ckr_if.master            bus,
    // Command port
    input  wire logic        cmd_valid,
    input  wire logic        cmd_read,
    input  wire logic [3:0]  cmd_ptr,
    input  wire logic [7:0]  cmd_wdata,
    output logic             cmd_ready,
    output logic             done,
    output logic             nack_err,
    output logic [7:0]       rdata
);
    ckr_pkg::ckr_mstate_t state_reg;
    logic [2:0] div_reg;
    logic [1:0] phase_reg;
    logic [2:0] bit_reg;
    logic [1:0] byte_reg;
    logic [7:0] tx_reg;
    logic       read_reg;
    logic [3:0] ptr_reg;
    logic [7:0] wdata_reg;
    logic       scl_reg;
    logic       sda_reg;
    logic [1:0] sda_sync_reg;
    logic       tick;

    assign tick = (div_reg == 3'(ckr_pkg::CKR_SCL_HALF - 1));
    assign cmd_ready = (state_reg == ckr_pkg::CKR_M_IDLE);

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            sda_sync_reg <= 2'h3;
        end else begin
            sda_sync_reg <= {sda_sync_reg[0], bus.sda};
        end
    end

    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_reg <= 3'h0;
        end else begin
            div_reg <= tick ? 3'h0 : div_reg + 3'h1;
        end
    end

    // Byte being sent: 0 addr+W, 1 pointer, 2 data or addr+R, 3 read data.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            state_reg <= ckr_pkg::CKR_M_IDLE;
            phase_reg <= 2'h0;
            bit_reg   <= 3'h0;
            byte_reg  <= 2'h0;
            tx_reg    <= 8'h00;
            read_reg  <= 1'b0;
            ptr_reg   <= 4'h0;
            wdata_reg <= 8'h00;
            scl_reg   <= 1'b1;
            sda_reg   <= 1'b1;
            done      <= 1'b0;
            nack_err  <= 1'b0;
            rdata     <= 8'h00;
        end else begin
            done <= 1'b0;
            case (state_reg)
                ckr_pkg::CKR_M_IDLE: begin
                    if (cmd_valid) begin
                        read_reg  <= cmd_read;
                        ptr_reg   <= cmd_ptr;
                        wdata_reg <= cmd_wdata;
                        byte_reg  <= 2'h0;
                        nack_err  <= 1'b0;
                        tx_reg    <= {ckr_pkg::CKR_SLAVE_ADDR, ckr_pkg::CKR_DIR_WRITE};
                        phase_reg <= 2'h0;
                        state_reg <= ckr_pkg::CKR_M_START;
                    end
                end
                ckr_pkg::CKR_M_START: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: begin sda_reg <= 1'b1; end
                        2'h1: begin scl_reg <= 1'b1; end
                        2'h2: begin sda_reg <= 1'b0; end
                        default: begin
                            scl_reg   <= 1'b0;
                            bit_reg   <= 3'h0;
                            phase_reg <= 2'h0;
                            state_reg <= ckr_pkg::CKR_M_BIT;
                        end
                    endcase
                end
                ckr_pkg::CKR_M_BIT: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: sda_reg <= (byte_reg == 2'h3) ? 1'b1 : tx_reg[7];
                        2'h1: scl_reg <= 1'b1;
                        2'h2: begin
                            tx_reg <= {tx_reg[6:0], sda_sync_reg[1]};
                        end
                        default: begin
                            scl_reg   <= 1'b0;
                            phase_reg <= 2'h0;
                            bit_reg   <= bit_reg + 3'h1;
                            if (bit_reg == ckr_pkg::CKR_BIT_LAST) begin
                                state_reg <= ckr_pkg::CKR_M_ACK;
                            end
                        end
                    endcase
                end
                ckr_pkg::CKR_M_ACK: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: sda_reg <= 1'b1; // Released: slave acks, read byte is not acked.
                        2'h1: scl_reg <= 1'b1;
                        2'h2: if (byte_reg != 2'h3 && sda_sync_reg[1]) nack_err <= 1'b1;
                        default: begin
                            scl_reg   <= 1'b0;
                            phase_reg <= 2'h0;
                            bit_reg   <= 3'h0;
                            if (nack_err || byte_reg == 2'h3
                                || (byte_reg == 2'h2 && !read_reg)) begin
                                if (byte_reg == 2'h3) rdata <= tx_reg;
                                state_reg <= ckr_pkg::CKR_M_STOP;
                            end else if (byte_reg == 2'h1 && read_reg) begin
                                byte_reg  <= 2'h2;
                                tx_reg    <= {ckr_pkg::CKR_SLAVE_ADDR, ckr_pkg::CKR_DIR_READ};
                                state_reg <= ckr_pkg::CKR_M_START;
                            end else begin
                                byte_reg  <= byte_reg + 2'h1;
                                tx_reg    <= (byte_reg == 2'h0) ? {4'h0, ptr_reg} : wdata_reg;
                                state_reg <= ckr_pkg::CKR_M_BIT;
                            end
                        end
                    endcase
                end
                ckr_pkg::CKR_M_STOP: if (tick) begin
                    phase_reg <= phase_reg + 2'h1;
                    case (phase_reg)
                        2'h0: sda_reg <= 1'b0;
                        2'h1: scl_reg <= 1'b1;
                        2'h2: sda_reg <= 1'b1;
                        default: begin
                            phase_reg <= 2'h0;
                            state_reg <= ckr_pkg::CKR_M_DONE;
                        end
                    endcase
                end
                ckr_pkg::CKR_M_DONE: begin
                    done      <= 1'b1;
                    state_reg <= ckr_pkg::CKR_M_IDLE;
                end
                default: state_reg <= ckr_pkg::CKR_M_IDLE;
            endcase
        end
    end

    assign bus.scl_o    = 1'b0;
    assign bus.scl_oe   = !scl_reg;
    assign bus.sda_m_o  = 1'b0;
    assign bus.sda_m_oe = !sda_reg;
endmodule : ckr_master

/* test/ckr_asserts.sv */
// Purpose: Protocol checks on the two-wire link between the two ends.
// Assumes: Sampled on clk_sys, which also makes SCL.
// Notes:   The bit counter restarts at each START.
`timescale 1ns/1ps
module ckr_asserts (
    // Clock and reset
    input  wire logic clk_sys,
    input  wire logic rstn,
    // Link
    input  wire logic scl,
    input  wire logic sda,
    input  wire logic sda_s_o,
    input  wire logic sda_s_oe,
    // Mode
    input  wire logic mode_run
);
    logic       scl_q, sda_q, first, rd;
    logic [3:0] cnt;
    logic [7:0] sh;
    wire rise  = scl && !scl_q;
    wire start = scl_q && scl && sda_q && !sda;
    wire stop  = scl_q && scl && !sda_q && sda;
    wire ack   = rise && (cnt == 4'h8);
    wire pull  = sda_s_oe && !sda_s_o;
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    // Counts SCL rises per byte and keeps the address byte.
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cnt <= 4'h0;
            first <= 1'b0;
            rd <= 1'b0;
            sh <= 8'h00;
        end else if (start) begin
            cnt <= 4'h0;
            first <= 1'b1;
        end else if (rise) begin
            cnt <= (cnt == 4'h8) ? 4'h0 : cnt + 4'h1;
            sh <= {sh[6:0], sda};
            if (first && cnt == 4'h7) rd <= sda;
            if (cnt == 4'h8) first <= 1'b0;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    sequence s_read_ack_slot;
        ack && !first && rd;
    endsequence
    property p_scl_high; $rose(scl) |-> scl[*4]; endproperty
    property p_scl_low; $fell(scl) |-> !scl[*4]; endproperty
    property p_slave_stable; scl && $past(scl) |-> $stable(pull); endproperty
    property p_addr_ack;
        ack && first && !mode_run && sh[7:1] == ckr_pkg::CKR_SLAVE_ADDR |-> !sda && pull;
    endproperty
    property p_read_nack; s_read_ack_slot |-> sda; endproperty
    property p_slave_release; s_read_ack_slot |=> !pull[*8]; endproperty
    property p_quiet_addr; first && cnt < 4'h8 |-> !pull; endproperty
    property p_whole_bytes; stop |-> cnt == 4'h1; endproperty
    a_scl_high: assert property (p_scl_high) else $error("scl high too short");
    a_scl_low: assert property (p_scl_low) else $error("scl low too short");
    a_slave_stable: assert property (p_slave_stable) else $error("sda moved");
    a_addr_ack: assert property (p_addr_ack) else $error("address not acked");
    a_read_nack: assert property (p_read_nack) else $error("last byte acked");
    a_slave_release: assert property (p_slave_release) else $error("sda held");
    a_quiet_addr: assert property (p_quiet_addr) else $error("slave drove addr");
    a_whole_bytes: assert property (p_whole_bytes) else $error("partial byte");
endmodule : ckr_asserts

/* test/ckr_slave_tb.sv */
// Purpose: Drives register writes and reads through the master into the slave.
// Assumes: Both ends joined by one link; clk_link unrelated to clk_sys.
// Notes:   Expected results queue up and are checked on each done pulse.
`timescale 1ns/1ps
module ckr_slave_tb;
    typedef struct packed {logic nk; logic rd; logic [7:0] val;} ckr_exp_t;
    logic         clk_sys = 0, clk_link = 0, rstn = 0, mode_run = 0;
    logic         cmd_valid = 0, cmd_read = 0, cmd_ready, done, nack_err;
    logic [3:0]   cmd_ptr = 4'h0;
    logic [7:0]   cmd_wdata = 8'h00, rdata, model [16];
    logic [127:0] regs_out;
    logic         prog_busy;
    ckr_exp_t     exp_q [$];
    int           failures = 0, n_compared = 0, cyc = 0, seed = 82, i;
    ckr_if bus_if ();
    ckr_master ckr_master_inst (.clk_sys(clk_sys), .rstn(rstn), .bus(bus_if),
        .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_ptr(cmd_ptr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .done(done),
        .nack_err(nack_err), .rdata(rdata));
    ckr_slave ckr_slave_inst (.clk_sys(clk_sys), .clk_link(clk_link), .rstn(rstn),
        .bus(bus_if), .mode_run(mode_run), .regs_out(regs_out), .prog_busy(prog_busy));
    ckr_asserts ckr_asserts_inst (.clk_sys(clk_sys), .rstn(rstn), .scl(bus_if.scl),
        .sda(bus_if.sda), .sda_s_o(bus_if.sda_s_o), .sda_s_oe(bus_if.sda_s_oe),
        .mode_run(mode_run));
    initial forever #12.5 clk_sys = ~clk_sys;
    initial begin
        #3.7;
        forever #6 clk_link = ~clk_link;
    end
    task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: byte %h expected %h", $time, got, exp);
        end
    endtask : cmp8
    task automatic cmp_regs();
        for (int k = 0; k < 16; k++) cmp8(regs_out[8*k +: 8], model[k]);
    endtask : cmp_regs
    task automatic end_of_test();
        $display("failures %0d, n_compared %0d", failures, n_compared);
        if (failures == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_of_test
    // Issues one command and waits for it to finish on the bus.
    task automatic do_cmd(input logic rd, input logic [3:0] p, input logic [7:0] d);
        @(negedge clk_sys);
        cmd_valid = 1'b1;
        cmd_read = rd;
        cmd_ptr = p;
        cmd_wdata = d;
        exp_q.push_back('{mode_run, rd, model[p]});
        @(posedge clk_sys);
        while (cmd_ready !== 1'b1) @(posedge clk_sys);
        @(negedge clk_sys);
        cmd_valid = 1'b0;
        while (done !== 1'b1) @(posedge clk_sys);
        if (!rd && !mode_run) model[p] = d;
        repeat (4) @(posedge clk_sys);
        while (prog_busy !== 1'b0) @(posedge clk_sys);
        repeat (4) @(posedge clk_sys);
    endtask : do_cmd
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 60000) begin
            failures++;
            end_of_test();
        end
    end
    // Checks each finished command against the oldest note.
    always @(posedge clk_sys) begin
        if (done === 1'b1 && exp_q.size() > 0) begin
            cmp8({7'h00, nack_err}, {7'h00, exp_q[0].nk});
            cmp8({7'h00, cmd_ready}, 8'h01);
            if (exp_q[0].rd && !exp_q[0].nk) cmp8(rdata, exp_q[0].val);
            void'(exp_q.pop_front());
        end
    end
    initial begin
        for (i = 0; i < 16; i++) model[i] = 8'h00;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys) rstn = 1'b1;
        cmp_regs();
        for (i = 0; i < 16; i++) begin
            do_cmd(1'b0, i[3:0], 8'($random(seed)));
            cmp_regs();
        end
        for (i = 15; i >= 0; i--) do_cmd(1'b1, i[3:0], 8'h00);
        do_cmd(1'b0, 4'hF, 8'hFF);
        do_cmd(1'b1, 4'hF, 8'h00);
        @(negedge clk_sys) mode_run = 1'b1;
        repeat (20) @(negedge clk_sys);
        do_cmd(1'b0, 4'h5, 8'hA5);
        cmp_regs();
        @(negedge clk_sys) mode_run = 1'b0;
        repeat (20) @(posedge clk_sys);
        for (i = 0; i < 16; i++) model[i] = 8'h00;
        cmp_regs();
        do_cmd(1'b1, 4'h3, 8'h00);
        end_of_test();
    end
endmodule : ckr_slave_tb
